// *** tb/adc_ch1_cfg_assertions.sv ***
`timescale 1ns/10ps
module adc_ch1_cfg_assertions
   import adc_ch1_cfg_pkg::*;
(
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0]        s_axi_wstrb,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              rangeModeSelect,
   input wire path_settings_t    pathSettings
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence respLater;
      ##2 s_axi_bvalid;
   endsequence

   write_answer_a: assert property (wrTaken |-> respLater)
      else $error("write response missing two cycles after address and data");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not valid one cycle after address");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before accepted");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before accepted");
   read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   mute_volume_a: assert property (pathSettings.muted |-> pathSettings.volumeHalfDb == 0)
      else $error("muted channel shows a volume");
   gain_range_a: assert property (pathSettings.gainHalfDb <= 84 && pathSettings.gainHalfDb >= -22)
      else $error("gain outside its range");
   trim_range_a: assert property (pathSettings.trimTenthDb >= -8 && pathSettings.trimTenthDb <= 7)
      else $error("trim outside its range");
   source_decode_a: assert property (pathSettings.digitalMicActive == (pathSettings.source == SRC_DIGITAL_MIC)
      && pathSettings.analogActive == (pathSettings.source < 2))
      else $error("source decode wrong");
   load_analog_a: assert property (!pathSettings.analogActive |-> pathSettings.load == LOAD_2K5
      && !pathSettings.dcCoupled)
      else $error("coupling or load shown for non analog source");
   range_mode_a: assert property (pathSettings.enhancerActive |-> !$past(rangeModeSelect)
      && !pathSettings.levelLoopActive)
      else $error("range processing kind wrong");
endmodule // adc_ch1_cfg_assertions

bind adc_channel_one_config_regs adc_ch1_cfg_assertions u_chk (
   .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .rangeModeSelect, .pathSettings
);

// *** tb/adc_channel_one_config_regs_bench.sv ***
`timescale 1ns/10ps
module adc_channel_one_config_regs_bench
   import adc_ch1_cfg_pkg::*;
;
   logic              clk, rstn, rangeModeSelect;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   path_settings_t    pathSettings;
   int                fail_count, n_tests;

   adc_channel_one_config_regs u_dut (
      .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .rangeModeSelect, .pathSettings
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
         fail_count++;
      end
   endtask

   // sample at the falling edge, act at the rising edge; response ready held back dly cycles
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input int dly);
      logic pa, pw, ta, tw, done;
      logic [1:0] r;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      done = 1'b0;
      r = 2'h3;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (dly == 0);
      while (!done && n < 40) begin
         @(negedge clk);
         ta = pa && s_axi_awready;
         tw = pw && s_axi_wready;
         done = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         n++;
         @(posedge clk);
         s_axi_awvalid <= pa && !ta;
         s_axi_wvalid <= pw && !tw;
         pa = pa && !ta;
         pw = pw && !tw;
         s_axi_bready <= !done && n >= dly;
      end
      if (!done)
         fail_count++;
      chk(r, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input int dly);
      logic pa, ta, done;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      pa = 1'b1;
      done = 1'b0;
      d = 32'h0;
      r = 2'h3;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (dly == 0);
      while (!done && n < 40) begin
         @(negedge clk);
         ta = pa && s_axi_arready;
         done = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         n++;
         @(posedge clk);
         s_axi_arvalid <= pa && !ta;
         pa = pa && !ta;
         s_axi_rready <= !done && n >= dly;
      end
      if (!done)
         fail_count++;
      chk(d, ed);
      chk(r, er);
   endtask

   task automatic t_reset;
      rd(ADDR_INPUT_SETUP, 32'h0, RESP_OKAY, 0);
      rd(ADDR_GAIN, 32'h0, RESP_OKAY, 0);
      rd(ADDR_VOLUME, 32'hC9, RESP_OKAY, 0);
      rd(ADDR_GAIN_TRIM, 32'h80, RESP_OKAY, 2);
      @(negedge clk);
      chk(pathSettings.volumeHalfDb, 32'h0);
      chk(pathSettings.trimTenthDb, 32'h0);
   endtask

   // every source code, both kinds, couplings and range modes; reserved bit 1 written as zero
   task automatic t_setup;
      logic [7:0] v;
      logic an;
      for (int k = 0; k < 4; k++) begin
         v = {k[0], k[1:0], ~k[0], k[1:0], 1'b0, k != 1};
         an = (k < 2);
         @(posedge clk);
         rangeModeSelect <= k[0];
         wr(ADDR_INPUT_SETUP, {24'h0, v}, RESP_OKAY, 0);
         rd(ADDR_INPUT_SETUP, {24'h0, v & 8'hFD}, RESP_OKAY, 0);
         @(negedge clk);
         chk(pathSettings.lineInput, v[7]);
         chk(pathSettings.source, v[6:5]);
         chk(pathSettings.digitalMicActive, k == 2);
         chk(pathSettings.analogActive, an);
         chk(pathSettings.dcCoupled, an & v[4]);
         chk(pathSettings.load, an ? v[3:2] : 2'h0);
         chk(pathSettings.enhancerActive, v[0] & ~k[0]);
         chk(pathSettings.levelLoopActive, v[0] & k[0]);
      end
      rd(ADDR_STATUS, 32'h81, RESP_OKAY, 0);
   endtask

   task automatic t_gain;
      logic [7:0] g[5] = '{8'hA8, 8'h02, 8'h2D, 8'h51, 8'h2D};
      int e[5] = '{84, 1, -22, -22, 0};
      wr(ADDR_INPUT_SETUP, 32'h04, RESP_OKAY, 0);
      for (int i = 0; i < 5; i++) begin
         if (i == 4)
            wr(ADDR_INPUT_SETUP, 32'h00, RESP_OKAY, 0);
         wr(ADDR_GAIN, {24'h0, g[i]}, RESP_OKAY, 0);
         rd(ADDR_GAIN, {24'h0, g[i]}, RESP_OKAY, 0);
         @(negedge clk);
         chk(pathSettings.gainHalfDb, e[i]);
      end
      rd(ADDR_STATUS, 32'h08, RESP_OKAY, 0);
   endtask

   task automatic t_volume;
      logic [7:0] c[4] = '{8'h00, 8'h01, 8'hFF, 8'hCA};
      int e[4] = '{0, -200, 54, 1};
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_VOLUME, {24'h0, c[i]}, RESP_OKAY, 0);
         rd(ADDR_VOLUME, {24'h0, c[i]}, RESP_OKAY, 0);
         @(negedge clk);
         chk(pathSettings.muted, c[i] == 8'h00);
         chk(pathSettings.volumeHalfDb, e[i]);
      end
   endtask

   task automatic t_trim;
      wr(ADDR_GAIN_TRIM, 32'hF0, RESP_OKAY, 0);
      rd(ADDR_GAIN_TRIM, 32'hF0, RESP_OKAY, 0);
      @(negedge clk);
      chk(pathSettings.trimTenthDb, 32'h7);
      wr(ADDR_GAIN_TRIM, 32'h00, RESP_OKAY, 0);
      rd(ADDR_GAIN_TRIM, 32'h00, RESP_OKAY, 0);
      @(negedge clk);
      chk(pathSettings.trimTenthDb, -8);
   endtask

   task automatic t_bus;
      wr(8'h04, 32'h55, RESP_SLVERR, 3);
      rd(8'h04, 32'h0, RESP_SLVERR, 0);
      wr(ADDR_STATUS, 32'hFF, RESP_SLVERR, 0);
      @(posedge clk);
      s_axi_wstrb <= 4'h0;
      wr(ADDR_VOLUME, 32'h11, RESP_OKAY, 0);
      @(posedge clk);
      s_axi_wstrb <= 4'hF;
      rd(ADDR_VOLUME, 32'hCA, RESP_OKAY, 0);
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      stop_test();
   end

   initial begin
      rstn = 1'b0;
      rangeModeSelect = 1'b0;
      s_axi_awaddr = 8'h0;
      s_axi_araddr = 8'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      fail_count = 0;
      n_tests = 0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_setup();
      t_gain();
      t_volume();
      t_trim();
      t_bus();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      stop_test();
   end
endmodule // adc_channel_one_config_regs_bench

// *** verilog/adc_ch1_cfg_pkg.sv ***
package adc_ch1_cfg_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;

   // register indices; byte address is four times the index
   localparam int IDX_INPUT_SETUP = 'h3C;
   localparam int IDX_GAIN        = 'h3D;
   localparam int IDX_VOLUME      = 'h3E;
   localparam int IDX_GAIN_TRIM   = 'h3F;
   localparam int IDX_STATUS      = 'h30;

   localparam logic [ADDR_W-1:0] ADDR_INPUT_SETUP = ADDR_W'(IDX_INPUT_SETUP * 4);
   localparam logic [ADDR_W-1:0] ADDR_GAIN        = ADDR_W'(IDX_GAIN * 4);
   localparam logic [ADDR_W-1:0] ADDR_VOLUME      = ADDR_W'(IDX_VOLUME * 4);
   localparam logic [ADDR_W-1:0] ADDR_GAIN_TRIM   = ADDR_W'(IDX_GAIN_TRIM * 4);
   localparam logic [ADDR_W-1:0] ADDR_STATUS      = ADDR_W'(IDX_STATUS * 4);

   // input setup fields
   localparam int KIND_BIT   = 7;
   localparam int SRC_HI     = 6;
   localparam int SRC_LO     = 5;
   localparam int COUPLE_BIT = 4;
   localparam int LOAD_HI    = 3;
   localparam int LOAD_LO    = 2;
   localparam int RANGE_BIT  = 0;
   // gain fields
   localparam int GAIN_HI    = 7;
   localparam int GAIN_LO    = 1;
   localparam int SIGN_BIT   = 0;
   // trim fields
   localparam int TRIM_HI    = 7;
   localparam int TRIM_LO    = 4;

   localparam logic [REG_W-1:0] RST_INPUT_SETUP  = 8'h00;
   localparam logic [REG_W-1:0] RST_GAIN         = 8'h00;
   localparam logic [REG_W-1:0] RST_VOLUME       = 8'hC9;
   localparam logic [REG_W-1:0] RST_GAIN_TRIM    = 8'h80;

   localparam logic [REG_W-1:0] MASK_INPUT_SETUP = 8'hFD;
   localparam logic [REG_W-1:0] MASK_GAIN        = 8'hFF;
   localparam logic [REG_W-1:0] MASK_VOLUME      = 8'hFF;
   localparam logic [REG_W-1:0] MASK_GAIN_TRIM   = 8'hF0;

   localparam logic [6:0] GAIN_MAX_CODE     = 7'h54;
   localparam logic [6:0] NEG_GAIN_MAX_CODE = 7'h16;
   localparam logic [7:0] VOL_MUTE_CODE     = 8'h00;
   localparam logic [8:0] VOL_ZERO_DB_CODE  = 9'h0C9;
   localparam logic [4:0] TRIM_ZERO_CODE    = 5'h08;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // status word bits
   localparam int ST_SRC_RSV   = 0;
   localparam int ST_LOAD_RSV  = 1;
   localparam int ST_GAIN_RSV  = 2;
   localparam int ST_NEG_BAD   = 3;
   localparam int ST_DIGITAL   = 4;
   localparam int ST_MUTED     = 5;
   localparam int ST_ENHANCER  = 6;
   localparam int ST_LEVEL     = 7;

   typedef enum logic [1:0] {
      SRC_ANALOG_DIFF = 2'b00,
      SRC_ANALOG_SE   = 2'b01,
      SRC_DIGITAL_MIC = 2'b10,
      SRC_RESERVED    = 2'b11
   } source_t;

   typedef enum logic [1:0] {
      LOAD_2K5      = 2'b00,
      LOAD_10K      = 2'b01,
      LOAD_20K      = 2'b10,
      LOAD_RESERVED = 2'b11
   } load_t;

   typedef struct packed {
      logic               lineInput;
      source_t            source;
      logic               analogActive;
      logic               digitalMicActive;
      logic               dcCoupled;
      load_t              load;
      logic               enhancerActive;
      logic               levelLoopActive;
      logic signed [7:0]  gainHalfDb;
      logic               muted;
      logic signed [8:0]  volumeHalfDb;
      logic signed [4:0]  trimTenthDb;
   } path_settings_t;

endpackage

// *** verilog/adc_channel_one_config_regs.sv ***
`timescale 1ns/10ps
module adc_channel_one_config_regs
   import adc_ch1_cfg_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              rangeModeSelect,
   output path_settings_t         pathSettings
);

   // write channel capture
   logic              awHeld_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic              wHeld_r;
   logic [REG_W-1:0]  wData_r;
   logic              wLane0_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              commit;
   logic              awFire;
   logic              wFire;
   logic              writeMapped;
   logic              laneOk;

   // read channel
   logic              rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0]        rresp_r;
   logic              arFire;
   logic [DATA_W-1:0] readWord;
   logic [1:0]        readResp;

   // register values
   logic [REG_W-1:0]  inputSetup;
   logic [REG_W-1:0]  gainReg;
   logic [REG_W-1:0]  volumeReg;
   logic [REG_W-1:0]  trimReg;
   logic              weInputSetup;
   logic              weGain;
   logic              weVolume;
   logic              weTrim;

   // decode
   path_settings_t    settings_nxt;
   path_settings_t    settings_r;
   logic [REG_W-1:0]  status_nxt;
   logic [REG_W-1:0]  status_r;
   source_t           srcCode;
   load_t             loadCode;
   logic [6:0]        gainCode;
   logic [6:0]        gainMag;
   logic              negAllowed;
   logic              negBad;
   logic              analogNow;
   logic              digitalNow;
   logic signed [7:0] gainHalf;
   logic              muteNow;
   logic signed [8:0] volumeHalf;
   logic signed [4:0] trimTenth;

   // ---------------------------------------------------------------- write path

   assign s_axi_awready = !awHeld_r && !bvalid_r;
   assign s_axi_wready  = !wHeld_r && !bvalid_r;
   assign awFire        = s_axi_awvalid && s_axi_awready;
   assign wFire         = s_axi_wvalid && s_axi_wready;
   assign commit        = awHeld_r && wHeld_r && !bvalid_r;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         awHeld_r <= 1'b0;
         awAddr_r <= '0;
      end else if (awFire) begin
         awHeld_r <= 1'b1;
         awAddr_r <= s_axi_awaddr;
      end else if (commit) begin
         awHeld_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wHeld_r  <= 1'b0;
         wData_r  <= '0;
         wLane0_r <= 1'b0;
      end else if (wFire) begin
         wHeld_r  <= 1'b1;
         wData_r  <= s_axi_wdata[REG_W-1:0];
         wLane0_r <= s_axi_wstrb[0];
      end else if (commit) begin
         wHeld_r <= 1'b0;
      end
   end

   // status is read-only, so a write to it is refused like an unmapped one
   always_comb begin
      writeMapped = 1'b0;
      unique case (awAddr_r)
         ADDR_INPUT_SETUP: writeMapped = 1'b1;
         ADDR_GAIN:        writeMapped = 1'b1;
         ADDR_VOLUME:      writeMapped = 1'b1;
         ADDR_GAIN_TRIM:   writeMapped = 1'b1;
         default:          writeMapped = 1'b0;
      endcase
   end

   // only byte lane 0 carries register bits
   assign laneOk       = commit && writeMapped && wLane0_r;
   assign weInputSetup = laneOk && (awAddr_r == ADDR_INPUT_SETUP);
   assign weGain       = laneOk && (awAddr_r == ADDR_GAIN);
   assign weVolume     = laneOk && (awAddr_r == ADDR_VOLUME);
   assign weTrim       = laneOk && (awAddr_r == ADDR_GAIN_TRIM);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (commit) begin
         bvalid_r <= 1'b1;
         bresp_r  <= writeMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;

   // ---------------------------------------------------------------- registers

   cfg_field #(
      .RESET_VALUE (RST_INPUT_SETUP),
      .WRITE_MASK  (MASK_INPUT_SETUP)
   ) u_input_setup (
      .clk       (clk),
      .rstn      (rstn),
      .writeEn   (weInputSetup),
      .writeData (wData_r),
      .value     (inputSetup)
   );

   cfg_field #(
      .RESET_VALUE (RST_GAIN),
      .WRITE_MASK  (MASK_GAIN)
   ) u_gain (
      .clk       (clk),
      .rstn      (rstn),
      .writeEn   (weGain),
      .writeData (wData_r),
      .value     (gainReg)
   );

   cfg_field #(
      .RESET_VALUE (RST_VOLUME),
      .WRITE_MASK  (MASK_VOLUME)
   ) u_volume (
      .clk       (clk),
      .rstn      (rstn),
      .writeEn   (weVolume),
      .writeData (wData_r),
      .value     (volumeReg)
   );

   cfg_field #(
      .RESET_VALUE (RST_GAIN_TRIM),
      .WRITE_MASK  (MASK_GAIN_TRIM)
   ) u_gain_trim (
      .clk       (clk),
      .rstn      (rstn),
      .writeEn   (weTrim),
      .writeData (wData_r),
      .value     (trimReg)
   );

   // ---------------------------------------------------------------- read path

   assign s_axi_arready = !rvalid_r;
   assign arFire        = s_axi_arvalid && s_axi_arready;

   always_comb begin
      readWord = '0;
      readResp = RESP_OKAY;
      unique case (s_axi_araddr)
         ADDR_INPUT_SETUP: readWord[REG_W-1:0] = inputSetup;
         ADDR_GAIN:        readWord[REG_W-1:0] = gainReg;
         ADDR_VOLUME:      readWord[REG_W-1:0] = volumeReg;
         ADDR_GAIN_TRIM:   readWord[REG_W-1:0] = trimReg;
         ADDR_STATUS:      readWord[REG_W-1:0] = status_r;
         default:          readResp = RESP_SLVERR;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= RESP_OKAY;
      end else if (arFire) begin
         rvalid_r <= 1'b1;
         rdata_r  <= readWord;
         rresp_r  <= readResp;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;

   // ---------------------------------------------------------------- decode

   assign srcCode    = source_t'(inputSetup[SRC_HI:SRC_LO]);
   assign loadCode   = load_t'(inputSetup[LOAD_HI:LOAD_LO]);
   assign gainCode   = gainReg[GAIN_HI:GAIN_LO];
   assign negAllowed = (loadCode == LOAD_10K) || (loadCode == LOAD_20K);
   assign negBad     = gainReg[SIGN_BIT] && !negAllowed;

   // reserved source leaves the channel with no active input
   always_comb begin
      analogNow  = 1'b0;
      digitalNow = 1'b0;
      unique case (srcCode)
         SRC_ANALOG_DIFF: analogNow  = 1'b1;
         SRC_ANALOG_SE:   analogNow  = 1'b1;
         SRC_DIGITAL_MIC: digitalNow = 1'b1;
         SRC_RESERVED:    analogNow  = 1'b0;
      endcase
   end

   // out-of-range codes are clamped rather than trusted
   always_comb begin
      gainMag  = '0;
      gainHalf = '0;
      if (gainReg[SIGN_BIT]) begin
         gainMag  = (gainCode > NEG_GAIN_MAX_CODE) ? NEG_GAIN_MAX_CODE : gainCode;
         gainHalf = negAllowed ? -$signed({1'b0, gainMag}) : 8'sh00;
      end else begin
         gainMag  = (gainCode > GAIN_MAX_CODE) ? GAIN_MAX_CODE : gainCode;
         gainHalf = $signed({1'b0, gainMag});
      end
   end

   always_comb begin
      muteNow    = (volumeReg == VOL_MUTE_CODE);
      volumeHalf = '0;
      if (!muteNow) begin
         volumeHalf = $signed({1'b0, volumeReg} - VOL_ZERO_DB_CODE);
      end
   end

   assign trimTenth = $signed({1'b0, trimReg[TRIM_HI:TRIM_LO]} - TRIM_ZERO_CODE);

   always_comb begin
      settings_nxt = '0;

      settings_nxt.lineInput        = inputSetup[KIND_BIT];
      settings_nxt.source           = srcCode;
      settings_nxt.analogActive     = analogNow;
      settings_nxt.digitalMicActive = digitalNow;

      // coupling and load only reach an analog front end
      settings_nxt.dcCoupled = analogNow && inputSetup[COUPLE_BIT];
      settings_nxt.load      = analogNow ? loadCode : LOAD_2K5;

      settings_nxt.enhancerActive  = inputSetup[RANGE_BIT] && !rangeModeSelect;
      settings_nxt.levelLoopActive = inputSetup[RANGE_BIT] && rangeModeSelect;

      settings_nxt.gainHalfDb   = gainHalf;
      settings_nxt.muted        = muteNow;
      settings_nxt.volumeHalfDb = volumeHalf;
      settings_nxt.trimTenthDb  = trimTenth;
   end

   always_comb begin
      status_nxt              = '0;
      status_nxt[ST_SRC_RSV]  = (srcCode == SRC_RESERVED);
      status_nxt[ST_LOAD_RSV] = settings_nxt.analogActive && (loadCode == LOAD_RESERVED);
      status_nxt[ST_GAIN_RSV] = (gainCode > GAIN_MAX_CODE);
      status_nxt[ST_NEG_BAD]  = negBad;
      status_nxt[ST_DIGITAL]  = settings_nxt.digitalMicActive;
      status_nxt[ST_MUTED]    = settings_nxt.muted;
      status_nxt[ST_ENHANCER] = settings_nxt.enhancerActive;
      status_nxt[ST_LEVEL]    = settings_nxt.levelLoopActive;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         // decode of the register reset values, so no false state follows reset
         settings_r              <= '0;
         settings_r.source       <= SRC_ANALOG_DIFF;
         settings_r.analogActive <= 1'b1;
         settings_r.load         <= LOAD_2K5;
         settings_r.gainHalfDb   <= 8'sh00;
         settings_r.volumeHalfDb <= 9'sh000;
         settings_r.trimTenthDb  <= 5'sh00;
      end else begin
         settings_r <= settings_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         status_r <= '0;
      end else begin
         status_r <= status_nxt;
      end
   end

   assign pathSettings = settings_r;

endmodule // adc_channel_one_config_regs

// *** verilog/cfg_field.sv ***
`timescale 1ns/10ps
module cfg_field
   import adc_ch1_cfg_pkg::*;
#(
   parameter logic [REG_W-1:0] RESET_VALUE = 8'h00,
   parameter logic [REG_W-1:0] WRITE_MASK  = 8'hFF
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             writeEn,
   input  wire logic [REG_W-1:0] writeData,
   output logic      [REG_W-1:0] value
);

   logic [REG_W-1:0] value_r;

   // masked bits stay at zero whatever is written
   always_ff @(posedge clk) begin
      if (!rstn) begin
         value_r <= RESET_VALUE;
      end else if (writeEn) begin
         value_r <= writeData & WRITE_MASK;
      end
   end

   assign value = value_r;

endmodule // cfg_field
